/* File: core/aocr_core.sv */
// Result coding, burnout control and reference supervision with an APB slave.
// Assumes filter results arrive as signed two's complement with a one-cycle valid,
// and that the comparator pins for reference fault are asynchronous levels.
// Functional notes
// - Unipolar results coded as straight binary
// - Bipolar results coded as offset binary
// - Polarity bit changes coding only
// - Burnout bit drives both currents together
// - Set reference-missing flag on low/open reference
// - Missing reference loads all ones as data
// - Missing reference inhibits calibration coefficient write
// - Channel switch holds ready high until settled
module aocr_core #(
  parameter int DATA_W = aocr_pkg::DATA_W,
  parameter int CHAN_W = aocr_pkg::CHAN_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_low_pin,
  input wire logic ref_open_pin,
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] result_signed,
  input wire logic result_settled,
  input wire logic [2:0] result_kind,
  output logic burnout_source_en,
  output logic burnout_sink_en,
  output logic unipolar_mode,
  output logic [CHAN_W-1:0] channel_sel,
  output logic ready_b
);
  logic ref_low;
  logic ref_open;
  logic reference_missing_flag;
  logic [31:0] ctrl;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] off_coef;
  logic [DATA_W-1:0] gain_coef;
  logic [DATA_W-1:0] coded;
  logic wr_en;
  logic rd_ok;
  logic chan_write;
  logic data_read;
  logic cal_ok;

  aocr_sync3 u_sync_low (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(ref_low_pin),
    .level(ref_low)
  );

  aocr_sync3 u_sync_open (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(ref_open_pin),
    .level(ref_open)
  );

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == aocr_pkg::OFS_CTRL) || (a == aocr_pkg::OFS_STATUS) ||
               (a == aocr_pkg::OFS_DATA) || (a == aocr_pkg::OFS_OFFCOEF) ||
               (a == aocr_pkg::OFS_GAINCOEF);
  endfunction : addr_hit

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign rd_ok = addr_hit(paddr);
  assign pslverr = psel && penable && !rd_ok;
  assign wr_en = psel && penable && pwrite && rd_ok;
  assign chan_write = wr_en && (paddr == aocr_pkg::OFS_CTRL) &&
    (pwdata[aocr_pkg::CTRL_CHAN_LSB +: CHAN_W] != channel_sel);
  assign data_read = psel && penable && !pwrite && (paddr == aocr_pkg::OFS_DATA);

  assign unipolar_mode = ctrl[aocr_pkg::CTRL_UNIPOLAR_BIT];
  assign channel_sel = ctrl[aocr_pkg::CTRL_CHAN_LSB +: CHAN_W];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl <= aocr_pkg::CTRL_RESET;
    end else if (wr_en && paddr == aocr_pkg::OFS_CTRL) begin
      ctrl <= pwdata;
    end
  end

  // Both current sources follow one bit so they can never be split
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      burnout_source_en <= 1'b0;
      burnout_sink_en <= 1'b0;
    end else begin
      burnout_source_en <= ctrl[aocr_pkg::CTRL_BURNOUT_BIT];
      burnout_sink_en <= ctrl[aocr_pkg::CTRL_BURNOUT_BIT];
    end
  end

  // Flag follows the filtered comparators, so it clears by itself
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reference_missing_flag <= 1'b0;
    end else begin
      reference_missing_flag <= ref_low || ref_open;
    end
  end

  // Coding only; the input path is untouched by the polarity bit
  always_comb begin
    if (unipolar_mode) begin
      // Negative results clamp to zero scale in straight binary
      // Repeating the LSB lets positive full scale reach all ones
      coded = result_signed[DATA_W-1] ? '0 :
        {result_signed[DATA_W-2:0], result_signed[0]};
    end else begin
      coded = {~result_signed[DATA_W-1], result_signed[DATA_W-2:0]};
    end
  end

  assign cal_ok = !reference_missing_flag;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      data_reg <= '0;
    end else if (result_valid && result_kind == aocr_pkg::AOCR_CONV_NORMAL) begin
      data_reg <= reference_missing_flag ? '1 : coded;
    end
  end

  // A fault during calibration keeps the old coefficient
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      off_coef <= aocr_pkg::OFFCOEF_RESET;
    end else if (wr_en && paddr == aocr_pkg::OFS_OFFCOEF) begin
      off_coef <= pwdata[DATA_W-1:0];
    end else if (result_valid && result_kind == aocr_pkg::AOCR_CONV_OFFCAL && cal_ok) begin
      off_coef <= result_signed;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gain_coef <= aocr_pkg::GAINCOEF_RESET;
    end else if (wr_en && paddr == aocr_pkg::OFS_GAINCOEF) begin
      gain_coef <= pwdata[DATA_W-1:0];
    end else if (result_valid && result_kind == aocr_pkg::AOCR_CONV_GAINCAL && cal_ok) begin
      gain_coef <= result_signed;
    end
  end

  // Ready is high after switch or read; a settled result wins over a same-cycle read
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ready_b <= 1'b1;
    end else if (chan_write) begin
      ready_b <= 1'b1;
    end else if (result_valid && result_settled &&
                 result_kind == aocr_pkg::AOCR_CONV_NORMAL) begin
      ready_b <= 1'b0;
    end else if (data_read) begin
      ready_b <= 1'b1;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      aocr_pkg::OFS_CTRL: prdata = ctrl;
      aocr_pkg::OFS_STATUS: begin
        prdata[aocr_pkg::STAT_REFMISS_BIT] = reference_missing_flag;
        prdata[aocr_pkg::STAT_READY_BIT] = ready_b;
      end
      aocr_pkg::OFS_DATA: prdata[DATA_W-1:0] = data_reg;
      aocr_pkg::OFS_OFFCOEF: prdata[DATA_W-1:0] = off_coef;
      aocr_pkg::OFS_GAINCOEF: prdata[DATA_W-1:0] = gain_coef;
      default: prdata = 32'h0000_0000;
    endcase
  end

  AST_UNI_CODE: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_valid && result_kind == aocr_pkg::AOCR_CONV_NORMAL && unipolar_mode &&
    !reference_missing_flag && result_signed == '0 |=> data_reg == '0)
    else $error("unipolar zero not coded as zero");
  AST_UNI_TOP: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_valid && result_kind == aocr_pkg::AOCR_CONV_NORMAL && unipolar_mode &&
    !reference_missing_flag && result_signed == {1'b0, {(DATA_W-1){1'b1}}} |=>
    data_reg == '1)
    else $error("unipolar full scale not coded as all ones");
  AST_BIP_CODE: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_valid && result_kind == aocr_pkg::AOCR_CONV_NORMAL && !unipolar_mode &&
    !reference_missing_flag |=> data_reg == {~$past(result_signed[DATA_W-1]),
    $past(result_signed[DATA_W-2:0])})
    else $error("bipolar coding wrong");
  AST_BIP_MID: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_valid && result_kind == aocr_pkg::AOCR_CONV_NORMAL && !unipolar_mode &&
    !reference_missing_flag && result_signed == '0 |=> data_reg[DATA_W-1] == 1'b1)
    else $error("bipolar zero missing top bit");
  AST_BURNOUT: assert property (@(posedge core_clk) disable iff (!rst_b)
    ##1 burnout_source_en == burnout_sink_en &&
    burnout_source_en == $past(ctrl[aocr_pkg::CTRL_BURNOUT_BIT]))
    else $error("burnout currents not switched together");
  AST_REFMISS_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ref_low || ref_open) |=> reference_missing_flag)
    else $error("reference missing flag not set");
  AST_ALL_ONES: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_valid && result_kind == aocr_pkg::AOCR_CONV_NORMAL &&
    reference_missing_flag |=> data_reg == '1)
    else $error("data not forced to all ones");
  AST_CAL_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_valid && result_kind == aocr_pkg::AOCR_CONV_OFFCAL && reference_missing_flag &&
    !(wr_en && paddr == aocr_pkg::OFS_OFFCOEF) |=> $stable(off_coef))
    else $error("offset coefficient written without reference");
  AST_GAIN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    result_valid && result_kind == aocr_pkg::AOCR_CONV_GAINCAL && reference_missing_flag &&
    !(wr_en && paddr == aocr_pkg::OFS_GAINCOEF) |=> $stable(gain_coef))
    else $error("gain coefficient written without reference");
  AST_CHAN_READY: assert property (@(posedge core_clk) disable iff (!rst_b)
    chan_write |=> ready_b)
    else $error("ready not raised on channel switch");
  AST_READY_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    ready_b && !(result_valid && result_settled &&
    result_kind == aocr_pkg::AOCR_CONV_NORMAL) |=> ready_b)
    else $error("ready dropped without a settled result");
  AST_REF_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
    !ref_low && !ref_open |=> !reference_missing_flag)
    else $error("reference flag did not clear");
endmodule : aocr_core

/* File: core/aocr_pkg.sv */
// Package for the result-coding and reference-supervision block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package aocr_pkg;
  localparam int DATA_W = 24;
  localparam int CHAN_W = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_OFFCOEF = 8'h0c;
  localparam logic [7:0] OFS_GAINCOEF = 8'h10;
  // Control field positions
  localparam int CTRL_UNIPOLAR_BIT = 0;
  localparam int CTRL_BURNOUT_BIT = 1;
  localparam int CTRL_CHAN_LSB = 4;
  // Status field positions
  localparam int STAT_REFMISS_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [23:0] OFFCOEF_RESET = 24'h80_0000;
  localparam logic [23:0] GAINCOEF_RESET = 24'h59_9999;
  // Conversion kinds reported with each filter result
  typedef enum logic [2:0] {
    AOCR_CONV_NORMAL = 3'b001,
    AOCR_CONV_OFFCAL = 3'b010,
    AOCR_CONV_GAINCAL = 3'b100
  } aocr_conv_t;
endpackage : aocr_pkg

/* File: core/aocr_sync3.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pin is a slow level; a change counts when stages two and three agree.
module aocr_sync3 (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule : aocr_sync3

/* File: verif/aocr_host.sv */
// Host model: an APB master that reads results and status from the block.
// Assumes one clock; the slave may stretch the access phase with pready.
module aocr_host (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Flag is worth reading at any time; it follows the filtered comparators, not the results
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never gets an answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so nothing relies on a stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : aocr_host

/* File: verif/adc_output_coding_refdetect_tb_top.sv */
// Bench for the coding and reference-supervision block.
// Assumes the host model on APB and a bench-driven filter result source.
module adc_output_coding_refdetect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ref_low_pin, ref_open_pin, result_valid, result_settled;
  logic [23:0] result_signed;
  logic [2:0] result_kind, channel_sel;
  logic burnout_source_en, burnout_sink_en, unipolar_mode, ready_b;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] ctl [6] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
  logic [23:0] vin [6] = '{24'h0, 24'h7fffff, 24'h800000, 24'h800000, 24'h0, 24'h7fffff};
  logic [23:0] vex [6] = '{24'h0, 24'hffffff, 24'h0, 24'h0, 24'h800000, 24'hffffff};
  aocr_core dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ref_low_pin, .ref_open_pin, .result_valid, .result_signed,
    .result_settled, .result_kind, .burnout_source_en, .burnout_sink_en, .unipolar_mode,
    .channel_sel, .ready_b);
  aocr_host host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp, m);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic push(input logic [2:0] k, input logic [23:0] v, input logic s);
    @(posedge core_clk);
    result_valid <= 1'b1;
    result_kind <= k;
    result_signed <= v;
    result_settled <= s;
    @(posedge core_clk);
    result_valid <= 1'b0;
    result_signed <= ~v;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : push
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("[FAIL] %0t run hung", $time);
    close_out();
  end
  initial begin
    {rst_b, ref_low_pin, ref_open_pin, result_valid, result_settled} = 5'h00;
    result_signed = 24'h0;
    result_kind = 3'h1;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    rchk(aocr_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    rchk(aocr_pkg::OFS_STATUS, 32'h2, "status reset");
    rchk(aocr_pkg::OFS_OFFCOEF, 32'h0080_0000, "offset coef reset");
    wr(aocr_pkg::OFS_CTRL, 32'h2);
    repeat (2) @(posedge core_clk);
    #1 chk({burnout_source_en, burnout_sink_en}, 2'b11, "burnout on");
    wr(aocr_pkg::OFS_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 chk({burnout_source_en, burnout_sink_en}, 2'b00, "burnout off");
    for (int i = 0; i < 6; i++) begin
      wr(aocr_pkg::OFS_CTRL, ctl[i]);
      #1 chk(unipolar_mode, ctl[i][0], "polarity");
      push(aocr_pkg::AOCR_CONV_NORMAL, vin[i], 1'b1);
      rchk(aocr_pkg::OFS_DATA, {8'h0, vex[i]}, "coding");
    end
    // Ready must be low first, or the switch check below could not trip
    push(aocr_pkg::AOCR_CONV_NORMAL, 24'h0, 1'b1);
    chk(ready_b, 1'b0, "ready low before switch");
    wr(aocr_pkg::OFS_CTRL, 32'h10);
    @(posedge core_clk);
    #1 chk({channel_sel, ready_b}, 4'h3, "switch holds ready");
    push(aocr_pkg::AOCR_CONV_NORMAL, 24'h0, 1'b0);
    chk(ready_b, 1'b1, "unsettled keeps ready high");
    push(aocr_pkg::AOCR_CONV_NORMAL, 24'h0, 1'b1);
    chk(ready_b, 1'b0, "settled drops ready");
    ref_low_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rchk(aocr_pkg::OFS_STATUS, 32'h1, "flag on low reference");
    push(aocr_pkg::AOCR_CONV_NORMAL, 24'h0, 1'b1);
    rchk(aocr_pkg::OFS_DATA, 32'h00ff_ffff, "all ones");
    rchk(aocr_pkg::OFS_STATUS, 32'h3, "flag after all ones");
    push(aocr_pkg::AOCR_CONV_OFFCAL, 24'h123456, 1'b1);
    rchk(aocr_pkg::OFS_OFFCOEF, 32'h0080_0000, "offset cal blocked");
    {ref_low_pin, ref_open_pin} <= 2'b01;
    repeat (8) @(posedge core_clk);
    push(aocr_pkg::AOCR_CONV_GAINCAL, 24'h123456, 1'b1);
    rchk(aocr_pkg::OFS_GAINCOEF, 32'h0059_9999, "gain cal blocked");
    rchk(aocr_pkg::OFS_STATUS, 32'h3, "flag on open input");
    ref_open_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    rchk(aocr_pkg::OFS_STATUS, 32'h2, "flag clears");
    push(aocr_pkg::AOCR_CONV_NORMAL, 24'h0, 1'b1);
    rchk(aocr_pkg::OFS_DATA, 32'h0080_0000, "results resume");
    push(aocr_pkg::AOCR_CONV_OFFCAL, 24'h123456, 1'b1);
    rchk(aocr_pkg::OFS_OFFCOEF, 32'h0012_3456, "offset cal loads");
    push(aocr_pkg::AOCR_CONV_GAINCAL, 24'h654321, 1'b1);
    rchk(aocr_pkg::OFS_GAINCOEF, 32'h0065_4321, "gain cal loads");
    wr(aocr_pkg::OFS_OFFCOEF, 32'h0000_0abc);
    rchk(aocr_pkg::OFS_OFFCOEF, 32'h0000_0abc, "offset coef write");
    wr(8'h20, 32'hffff_ffff);
    chk(er, 1'b1, "unmapped write error");
    rchk(8'h20, 32'h0, "unmapped read");
    close_out();
  end
endmodule : adc_output_coding_refdetect_tb_top
